/* rtl/mbr_pkg.sv */
package mbr_pkg;
  // response status codes
  localparam logic [9:0] MBR_ST_OK                   = 10'h000;
  localparam logic [9:0] MBR_ST_BOOT_UNDECODABLE     = 10'h001;
  localparam logic [9:0] MBR_ST_FIRMWARE_UNDECODABLE = 10'h003;
  localparam logic [9:0] MBR_ST_MALFORMED            = 10'h004;
  localparam logic [9:0] MBR_ST_SOURCE_DISABLED      = 10'h006;
  localparam logic [9:0] MBR_ST_OWNER_MISMATCH       = 10'h008;
  localparam logic [9:0] MBR_ST_BAD_ADDRESS          = 10'h009;
  localparam logic [9:0] MBR_ST_AUTH_FAIL            = 10'h00a;
  localparam logic [9:0] MBR_ST_TIMEOUT              = 10'h00b;
  localparam logic [9:0] MBR_ST_HARDWARE_UNPREPARED  = 10'h00c;
  localparam logic [9:0] MBR_ST_HARDWARE_FAULT       = 10'h00d;
  localparam logic [9:0] MBR_ST_FLASH_PORT_FAULT     = 10'h080;
  localparam logic [9:0] MBR_ST_FLASH_ALREADY_OWNED  = 10'h081;
  localparam logic [9:0] MBR_ST_FUSE_CACHE_FAULT     = 10'h082;
  localparam logic [9:0] MBR_ST_SPECIFIC_LAST        = 10'h08f;
  localparam logic [9:0] MBR_ST_UNPROGRAMMED_DEVICE  = 10'h100;
  localparam logic [9:0] MBR_ST_MANAGER_OCCUPIED     = 10'h1ff;
  localparam logic [9:0] MBR_ST_REPLY_ABSENT         = 10'h2ff;
  localparam logic [9:0] MBR_ST_GENERIC_FAILURE      = 10'h3ff;

  // fault inputs, one bit each, in priority order (bit 0 highest)
  localparam int MBR_F_BOOT_UNDECODABLE     = 0;
  localparam int MBR_F_FIRMWARE_UNDECODABLE = 1;
  localparam int MBR_F_SOURCE_DISABLED      = 2;
  localparam int MBR_F_MALFORMED            = 3;
  localparam int MBR_F_MANAGER_OCCUPIED     = 4;
  localparam int MBR_F_UNPROGRAMMED_DEVICE  = 5;
  localparam int MBR_F_HARDWARE_UNPREPARED  = 6;
  localparam int MBR_F_BAD_ADDRESS          = 7;
  localparam int MBR_F_AUTH_FAIL            = 8;
  localparam int MBR_F_TIMEOUT              = 9;
  localparam int MBR_F_HARDWARE_FAULT       = 10;
  localparam int MBR_F_FLASH_PORT_FAULT     = 11;
  localparam int MBR_F_FUSE_CACHE_FAULT     = 12;
  localparam int MBR_F_NO_REPLY             = 13;
  localparam int MBR_F_GENERIC              = 14;
  localparam int MBR_FAULT_W                = 15;

  // header layout: [9:0] status, [20:10] length, [24:21] id echo, [28:25] client echo
  localparam int MBR_HDR_ST_LSB  = 0;
  localparam int MBR_HDR_LEN_LSB = 10;
  localparam int MBR_HDR_ID_LSB  = 21;
  localparam int MBR_HDR_CL_LSB  = 25;
  localparam int MBR_LEN_W       = 11;
  localparam int MBR_ST_W        = 10;
  localparam int MBR_ID_W        = 4;

  // command header: [10:0] opcode, [21:11] length, [25:22] id, [29:26] client
  localparam int MBR_CMD_OP_LSB  = 0;
  localparam int MBR_CMD_LEN_LSB = 11;
  localparam int MBR_CMD_ID_LSB  = 22;
  localparam int MBR_CMD_CL_LSB  = 26;
  localparam int MBR_OP_W        = 11;

  localparam logic [MBR_OP_W-1:0] MBR_OP_FLASH_LOCK    = 11'h030;
  localparam logic [MBR_OP_W-1:0] MBR_OP_FLASH_UNLOCK  = 11'h031;
  localparam logic [MBR_OP_W-1:0] MBR_OP_READ_DIE_ID   = 11'h012;

  localparam int MBR_CMD_DEPTH  = 16;
  localparam int MBR_RSP_DEPTH  = 24;
  localparam int MBR_AXI_DATA_W = 64;
endpackage

/* rtl/mbr_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface mbr_link_if;
  import mbr_pkg::*;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_last;
  logic [31:0] cmd_data;
  logic        rsp_valid;
  logic        rsp_ready;
  logic        rsp_last;
  logic [31:0] rsp_data;
  modport host (output cmd_valid, cmd_last, cmd_data, rsp_ready,
                input  cmd_ready, rsp_valid, rsp_last, rsp_data);
  modport dev  (input  cmd_valid, cmd_last, cmd_data, rsp_ready,
                output cmd_ready, rsp_valid, rsp_last, rsp_data);
endinterface
`default_nettype wire

/* rtl/mbr_device.sv */
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - success reports status zero
// - boot firmware undecodable reports one
// - runtime firmware undecodable reports three
// - malformed command reports four
// - source not enabled reports six
// - release by non-owner reports eight
// - address faults report nine
// - signature failure reports A
// - flash or thermal timeout reports B
// - hardware unprepared reports C
// - unrecoverable hardware fault reports D
// - specific codes 80-8F; die id 82
// - flash fault 80; already owner 81
// - busy manager reports 1FF
// - no reply 2FF; general error 3FF
// - host resends corrected command on four
// - host waits for owner release on eight
// - host proceeds on already owned
// - host retries thermal timeout
// - queue depths are build parameters
// - crypto option adds 64-bit AXI manager
// - host reads data only after zero status
module mbr_device
  import mbr_pkg::*;
#(
  parameter int CMD_DEPTH  = MBR_CMD_DEPTH,
  parameter int RSP_DEPTH  = MBR_RSP_DEPTH,
  parameter bit CRYPTO_EN  = 1'b0
) (
  // clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        reset_in,
  // link to host
  mbr_link_if.dev                          link,
  // service side: command words out, outcome in
  output logic                             svc_cmd_valid_out,
  output logic [31:0]                      svc_cmd_data_out,
  output logic                             svc_cmd_last_out,
  input  wire logic                        svc_done_in,
  input  wire logic [MBR_FAULT_W-1:0]      svc_fault_in,
  input  wire logic [MBR_LEN_W-1:0]        svc_len_in,
  input  wire logic                        svc_data_valid_in,
  input  wire logic [31:0]                 svc_data_in,
  output logic                             svc_data_ready_out,
  // crypto AXI manager (write channel only, used when enabled)
  input  wire logic                        crypto_req_in,
  input  wire logic [31:0]                 crypto_addr_in,
  input  wire logic [MBR_AXI_DATA_W-1:0]   crypto_data_in,
  output logic                             m_axi_awvalid,
  input  wire logic                        m_axi_awready,
  output logic [31:0]                      m_axi_awaddr,
  output logic                             m_axi_wvalid,
  input  wire logic                        m_axi_wready,
  output logic [MBR_AXI_DATA_W-1:0]        m_axi_wdata,
  output logic [MBR_AXI_DATA_W/8-1:0]      m_axi_wstrb,
  output logic                             m_axi_wlast,
  input  wire logic                        m_axi_bvalid,
  output logic                             m_axi_bready,
  output logic                             crypto_busy_out
);
  initial begin
    if (CMD_DEPTH < 2 || RSP_DEPTH < 2 || CMD_DEPTH > 1024 || RSP_DEPTH > 1024) begin
      $error("mbr_device: queue depth out of range");
    end
  end

  typedef enum logic [3:0] {
    MBR_S_CMD  = 4'b0001,
    MBR_S_WAIT = 4'b0010,
    MBR_S_HDR  = 4'b0100,
    MBR_S_DATA = 4'b1000
  } mbr_dev_state_t;

  mbr_dev_state_t state_ff;
  logic [31:0] cmd_hdr_ff;
  logic        first_ff;
  logic        owned_ff;
  localparam int ID_BITS_W = MBR_ID_W;
  logic [ID_BITS_W-1:0] owner_ff;
  logic [MBR_ST_W-1:0]  status_ff;
  logic [MBR_LEN_W-1:0] rsp_left_ff;
  logic [MBR_ST_W-1:0]  nxt_status;

  wire logic [MBR_OP_W-1:0] cmd_op     = cmd_hdr_ff[MBR_CMD_OP_LSB +: MBR_OP_W];
  wire logic [ID_BITS_W-1:0] cmd_client = cmd_hdr_ff[MBR_CMD_CL_LSB +: ID_BITS_W];

  // command words pass straight through, depth lives in the host queue
  assign link.cmd_ready      = (state_ff == MBR_S_CMD);
  assign svc_cmd_valid_out   = link.cmd_valid && (state_ff == MBR_S_CMD);
  assign svc_cmd_data_out    = link.cmd_data;
  assign svc_cmd_last_out    = link.cmd_last;

  // fixed priority: decode faults before resource faults
  always_comb begin
    nxt_status = MBR_ST_OK;
    if (svc_fault_in[MBR_F_BOOT_UNDECODABLE])          nxt_status = MBR_ST_BOOT_UNDECODABLE;
    else if (svc_fault_in[MBR_F_FIRMWARE_UNDECODABLE]) nxt_status = MBR_ST_FIRMWARE_UNDECODABLE;
    else if (svc_fault_in[MBR_F_SOURCE_DISABLED])      nxt_status = MBR_ST_SOURCE_DISABLED;
    else if (svc_fault_in[MBR_F_MALFORMED])            nxt_status = MBR_ST_MALFORMED;
    else if (svc_fault_in[MBR_F_MANAGER_OCCUPIED])     nxt_status = MBR_ST_MANAGER_OCCUPIED;
    else if (svc_fault_in[MBR_F_UNPROGRAMMED_DEVICE])  nxt_status = MBR_ST_UNPROGRAMMED_DEVICE;
    else if (svc_fault_in[MBR_F_HARDWARE_UNPREPARED])  nxt_status = MBR_ST_HARDWARE_UNPREPARED;
    else if (cmd_op == MBR_OP_FLASH_UNLOCK && owned_ff && owner_ff != cmd_client)
      nxt_status = MBR_ST_OWNER_MISMATCH;
    else if (cmd_op == MBR_OP_FLASH_LOCK && owned_ff && owner_ff == cmd_client)
      nxt_status = MBR_ST_FLASH_ALREADY_OWNED;
    else if (svc_fault_in[MBR_F_BAD_ADDRESS])          nxt_status = MBR_ST_BAD_ADDRESS;
    else if (svc_fault_in[MBR_F_AUTH_FAIL])            nxt_status = MBR_ST_AUTH_FAIL;
    else if (svc_fault_in[MBR_F_TIMEOUT])              nxt_status = MBR_ST_TIMEOUT;
    else if (svc_fault_in[MBR_F_HARDWARE_FAULT])       nxt_status = MBR_ST_HARDWARE_FAULT;
    else if (svc_fault_in[MBR_F_FLASH_PORT_FAULT])     nxt_status = MBR_ST_FLASH_PORT_FAULT;
    else if (svc_fault_in[MBR_F_FUSE_CACHE_FAULT] && cmd_op == MBR_OP_READ_DIE_ID)
      nxt_status = MBR_ST_FUSE_CACHE_FAULT;
    else if (svc_fault_in[MBR_F_NO_REPLY])             nxt_status = MBR_ST_REPLY_ABSENT;
    else if (|svc_fault_in)                            nxt_status = MBR_ST_GENERIC_FAILURE;
  end

  // sequencing
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_ff    <= MBR_S_CMD;
      first_ff    <= 1'b1;
      cmd_hdr_ff  <= 32'h0000_0000;
      status_ff   <= MBR_ST_OK;
      rsp_left_ff <= '0;
    end else begin
      unique case (state_ff)
        MBR_S_CMD: begin
          if (link.cmd_valid) begin
            if (first_ff) begin
              cmd_hdr_ff <= link.cmd_data;
            end
            first_ff <= link.cmd_last;
            if (link.cmd_last) begin
              state_ff <= MBR_S_WAIT;
            end
          end
        end
        MBR_S_WAIT: begin
          if (svc_done_in) begin
            status_ff   <= nxt_status;
            // only a clean outcome carries data words
            rsp_left_ff <= (nxt_status == MBR_ST_OK) ? svc_len_in : '0;
            state_ff    <= MBR_S_HDR;
          end
        end
        MBR_S_HDR: begin
          if (link.rsp_ready) begin
            state_ff <= (rsp_left_ff == '0) ? MBR_S_CMD : MBR_S_DATA;
          end
        end
        MBR_S_DATA: begin
          if (link.rsp_ready && svc_data_valid_in) begin
            rsp_left_ff <= rsp_left_ff - 1'b1;
            if (rsp_left_ff == 11'h001) begin
              state_ff <= MBR_S_CMD;
            end
          end
        end
      endcase
    end
  end

  // flash ownership: single owner, replaced by another client's successful lock
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      owned_ff <= 1'b0;
      owner_ff <= '0;
    end else if (state_ff == MBR_S_WAIT && svc_done_in && nxt_status == MBR_ST_OK) begin
      if (cmd_op == MBR_OP_FLASH_LOCK) begin
        owned_ff <= 1'b1;
        owner_ff <= cmd_client;
      end else if (cmd_op == MBR_OP_FLASH_UNLOCK) begin
        owned_ff <= 1'b0;
      end
    end
  end

  // response header: status, length, echoes
  wire logic [31:0] rsp_hdr = {3'b000,
                               cmd_hdr_ff[MBR_CMD_CL_LSB +: MBR_ID_W],
                               cmd_hdr_ff[MBR_CMD_ID_LSB +: MBR_ID_W],
                               rsp_left_ff,
                               status_ff};
  assign link.rsp_valid   = (state_ff == MBR_S_HDR) || (state_ff == MBR_S_DATA && svc_data_valid_in);
  assign link.rsp_data    = (state_ff == MBR_S_HDR) ? rsp_hdr : svc_data_in;
  assign link.rsp_last    = (state_ff == MBR_S_HDR) ? (rsp_left_ff == '0) : (rsp_left_ff == 11'h001);
  assign svc_data_ready_out = (state_ff == MBR_S_DATA) && link.rsp_ready;

  // optional crypto offload port
  generate
    if (CRYPTO_EN) begin : g_crypto
      logic aw_ff;
      logic w_ff;
      logic b_ff;
      logic [31:0] addr_ff;
      logic [MBR_AXI_DATA_W-1:0] data_ff;
      always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
          aw_ff   <= 1'b0;
          w_ff    <= 1'b0;
          b_ff    <= 1'b0;
          addr_ff <= 32'h0000_0000;
          data_ff <= '0;
        end else if (!aw_ff && !w_ff && !b_ff) begin
          if (crypto_req_in) begin
            aw_ff   <= 1'b1;
            w_ff    <= 1'b1;
            addr_ff <= crypto_addr_in;
            data_ff <= crypto_data_in;
          end
        end else begin
          if (aw_ff && m_axi_awready) aw_ff <= 1'b0;
          if (w_ff && m_axi_wready) w_ff <= 1'b0;
          if ((aw_ff && m_axi_awready) || (w_ff && m_axi_wready)) b_ff <= 1'b1;
          if (b_ff && !aw_ff && !w_ff && m_axi_bvalid) b_ff <= 1'b0;
        end
      end
      assign m_axi_awvalid   = aw_ff;
      assign m_axi_awaddr    = addr_ff;
      assign m_axi_wvalid    = w_ff;
      assign m_axi_wdata     = data_ff;
      assign m_axi_wstrb     = '1;
      assign m_axi_wlast     = 1'b1;
      assign m_axi_bready    = b_ff && !aw_ff && !w_ff;
      assign crypto_busy_out = aw_ff || w_ff || b_ff;
    end else begin : g_no_crypto
      assign m_axi_awvalid   = 1'b0;
      assign m_axi_awaddr    = 32'h0000_0000;
      assign m_axi_wvalid    = 1'b0;
      assign m_axi_wdata     = '0;
      assign m_axi_wstrb     = '0;
      assign m_axi_wlast     = 1'b0;
      assign m_axi_bready    = 1'b0;
      assign crypto_busy_out = 1'b0;
    end
  endgenerate
endmodule
`default_nettype wire

/* rtl/mbr_host.sv */
`timescale 1ns/1ns
`default_nettype none
module mbr_host
  import mbr_pkg::*;
#(
  parameter int CMD_DEPTH = MBR_CMD_DEPTH
) (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  // link to device
  mbr_link_if.host                    link,
  // user command side
  input  wire logic                   usr_cmd_valid_in,
  input  wire logic [31:0]            usr_cmd_data_in,
  input  wire logic                   usr_cmd_last_in,
  output logic                        usr_cmd_ready_out,
  // user response side
  output logic                        usr_hdr_valid_out,
  output logic [MBR_ST_W-1:0]         usr_status_out,
  output logic [MBR_LEN_W-1:0]        usr_len_out,
  output logic                        usr_data_valid_out,
  output logic [31:0]                 usr_data_out,
  output logic                        usr_retry_out,
  output logic                        usr_flash_owned_out
);
  localparam int PTR_W = $clog2(CMD_DEPTH);
  initial begin
    if (CMD_DEPTH < 2 || CMD_DEPTH > 1024 || (CMD_DEPTH & (CMD_DEPTH - 1)) != 0) begin
      $error("mbr_host: depth must be a power of two, 2..1024");
    end
  end

  // command queue sized for the longest back-to-back burst
  logic [32:0] mem_ff [CMD_DEPTH];
  logic [PTR_W:0] wr_ff;
  logic [PTR_W:0] rd_ff;
  logic in_rsp_ff;
  logic hdr_seen_ff;
  wire logic full  = (wr_ff[PTR_W] != rd_ff[PTR_W]) && (wr_ff[PTR_W-1:0] == rd_ff[PTR_W-1:0]);
  wire logic empty = (wr_ff == rd_ff);

  assign usr_cmd_ready_out = !full;
  assign link.cmd_valid    = !empty;
  assign link.cmd_data     = mem_ff[rd_ff[PTR_W-1:0]][31:0];
  assign link.cmd_last     = mem_ff[rd_ff[PTR_W-1:0]][32];
  assign link.rsp_ready    = 1'b1;

  always_ff @(posedge clk_in) begin
    if (usr_cmd_valid_in && !full) begin
      mem_ff[wr_ff[PTR_W-1:0]] <= {usr_cmd_last_in, usr_cmd_data_in};
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (usr_cmd_valid_in && !full) wr_ff <= wr_ff + 1'b1;
      if (!empty && link.cmd_ready) rd_ff <= rd_ff + 1'b1;
    end
  end

  wire logic [MBR_ST_W-1:0] rx_status = link.rsp_data[MBR_HDR_ST_LSB +: MBR_ST_W];

  // response intake; data words only pass after a zero status
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      in_rsp_ff           <= 1'b0;
      hdr_seen_ff         <= 1'b0;
      usr_hdr_valid_out   <= 1'b0;
      usr_status_out      <= MBR_ST_OK;
      usr_len_out         <= '0;
      usr_data_valid_out  <= 1'b0;
      usr_data_out        <= 32'h0000_0000;
      usr_retry_out       <= 1'b0;
      usr_flash_owned_out <= 1'b0;
    end else begin
      usr_hdr_valid_out  <= 1'b0;
      usr_data_valid_out <= 1'b0;
      usr_retry_out      <= 1'b0;
      if (link.rsp_valid) begin
        if (!in_rsp_ff) begin
          usr_hdr_valid_out <= 1'b1;
          usr_status_out    <= rx_status;
          usr_len_out       <= link.rsp_data[MBR_HDR_LEN_LSB +: MBR_LEN_W];
          hdr_seen_ff       <= (rx_status == MBR_ST_OK);
          // malformed, owner busy, or timeout: user must resend
          usr_retry_out     <= (rx_status == MBR_ST_MALFORMED) || (rx_status == MBR_ST_OWNER_MISMATCH) ||
                               (rx_status == MBR_ST_TIMEOUT);
          if (rx_status == MBR_ST_FLASH_ALREADY_OWNED) usr_flash_owned_out <= 1'b1;
        end else if (hdr_seen_ff) begin
          usr_data_valid_out <= 1'b1;
          usr_data_out       <= link.rsp_data;
        end
        in_rsp_ff <= !link.rsp_last;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/mbr_link_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module mbr_link_assertions
  import mbr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // command stream
  input  wire logic        cmd_valid,
  input  wire logic        cmd_ready,
  input  wire logic        cmd_last,
  input  wire logic [31:0] cmd_data,
  // response stream
  input  wire logic        rsp_valid,
  input  wire logic        rsp_ready,
  input  wire logic        rsp_last,
  input  wire logic [31:0] rsp_data
);
  logic                 first_ff;
  logic [MBR_LEN_W-1:0] left_ff;
  logic                 take;
  logic                 hdr;
  logic                 rsp_end;
  logic [MBR_ST_W-1:0]  st;
  logic [MBR_LEN_W-1:0] len;
  assign take    = rsp_valid && rsp_ready;
  assign hdr     = rsp_valid && first_ff;
  assign rsp_end = take && rsp_last;
  assign st      = rsp_data[MBR_HDR_ST_LSB +: MBR_ST_W];
  assign len     = rsp_data[MBR_HDR_LEN_LSB +: MBR_LEN_W];
  // first word of every response is the header
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      first_ff <= 1'b1;
    end else if (take) begin
      first_ff <= rsp_last;
    end
  end
  // data words still owed after the header
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      left_ff <= '0;
    end else if (take && first_ff) begin
      left_ff <= len;
    end else if (take) begin
      left_ff <= left_ff - 11'h001;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  a_busy_refuses_cmd: assert property (rsp_valid |-> !cmd_ready)
    else $error("command accepted while a response is pending");
  a_last_closes_cmd: assert property (cmd_valid && cmd_ready && cmd_last |=> !cmd_ready)
    else $error("command port reopened before response");
  a_rsp_holds_word: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("response word changed before acceptance");
  a_fail_no_length: assert property (hdr && st != MBR_ST_OK |-> len == 11'h000 && rsp_last)
    else $error("failed response carries data");
  a_empty_hdr_last: assert property (hdr && len == 11'h000 |-> rsp_last)
    else $error("empty response not marked last");
  a_specific_range: assert property (hdr && st[9:4] == 6'h08 |-> st <= MBR_ST_FUSE_CACHE_FAULT)
    else $error("unused command specific code");
  a_last_on_final: assert property (rsp_valid && !first_ff |-> left_ff != 11'h000 && rsp_last == (left_ff == 11'h001))
    else $error("last marker misplaced in response data");
  a_ready_after_rsp: assert property ($rose(cmd_ready) |-> $past(rsp_end))
    else $error("command port reopened without response end");
endmodule
`default_nettype wire

/* sim/test_mailbox_response_error_codes.sv */
`timescale 1ns/1ns
`default_nettype none
module test_mailbox_response_error_codes;
  import mbr_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic ucv = 1'b0, ucl = 1'b0, done = 1'b0, sdv = 1'b0, creq = 1'b0;
  logic awr = 1'b0, wr = 1'b0, bv = 1'b0;
  logic [31:0] ucd = '0, sdd = '0, caddr = '0;
  logic [63:0] cdat = '0;
  logic [14:0] flt = '0;
  logic [10:0] slen = '0;
  wire logic ucr, hv, dv, rty, own, scv, scl, sdr, awv, wv, wl, br, busy;
  wire logic [9:0] ust;
  wire logic [10:0] ulen;
  wire logic [31:0] udat, scd, awa;
  wire logic [63:0] wd;
  wire logic [7:0] ws;
  int unsigned failures = 0, check_count = 0, hdr_n = 0, retry_n = 0, cmd_n = 0;
  logic [31:0] got_cmd, link_hdr;
  logic got_last = 1'b0;
  logic link_first = 1'b1;
  logic [31:0] dq[$];
  logic [3:0] id = 4'h0;

  always #20 clk_in = ~clk_in;

  mbr_link_if u_mbr_link_if ();
  mbr_host u_mbr_host (.clk_in(clk_in), .reset_in(reset_in), .link(u_mbr_link_if),
    .usr_cmd_valid_in(ucv), .usr_cmd_data_in(ucd), .usr_cmd_last_in(ucl), .usr_cmd_ready_out(ucr),
    .usr_hdr_valid_out(hv), .usr_status_out(ust), .usr_len_out(ulen), .usr_data_valid_out(dv),
    .usr_data_out(udat), .usr_retry_out(rty), .usr_flash_owned_out(own));
  mbr_device #(.CRYPTO_EN(1'b1)) u_mbr_device (.clk_in(clk_in), .reset_in(reset_in), .link(u_mbr_link_if),
    .svc_cmd_valid_out(scv), .svc_cmd_data_out(scd), .svc_cmd_last_out(scl), .svc_done_in(done),
    .svc_fault_in(flt), .svc_len_in(slen), .svc_data_valid_in(sdv), .svc_data_in(sdd),
    .svc_data_ready_out(sdr), .crypto_req_in(creq), .crypto_addr_in(caddr), .crypto_data_in(cdat),
    .m_axi_awvalid(awv), .m_axi_awready(awr), .m_axi_awaddr(awa), .m_axi_wvalid(wv), .m_axi_wready(wr),
    .m_axi_wdata(wd), .m_axi_wstrb(ws), .m_axi_wlast(wl), .m_axi_bvalid(bv), .m_axi_bready(br),
    .crypto_busy_out(busy));
  mbr_link_assertions u_mbr_link_assertions (.clk_in(clk_in), .reset_in(reset_in),
    .cmd_valid(u_mbr_link_if.cmd_valid), .cmd_ready(u_mbr_link_if.cmd_ready),
    .cmd_last(u_mbr_link_if.cmd_last), .cmd_data(u_mbr_link_if.cmd_data),
    .rsp_valid(u_mbr_link_if.rsp_valid), .rsp_ready(u_mbr_link_if.rsp_ready),
    .rsp_last(u_mbr_link_if.rsp_last), .rsp_data(u_mbr_link_if.rsp_data));

  // pulses are counted here so a scenario never misses a one-cycle strobe
  always @(posedge clk_in) begin
    if (hv === 1'b1) hdr_n++;
    if (rty === 1'b1) retry_n++;
    if (dv === 1'b1) dq.push_back(udat);
    if (scv === 1'b1) begin
      cmd_n++;
      got_cmd = scd;
      got_last = scl;
    end
    if (u_mbr_link_if.rsp_valid === 1'b1 && u_mbr_link_if.rsp_ready === 1'b1) begin
      if (link_first) link_hdr = u_mbr_link_if.rsp_data;
      link_first = u_mbr_link_if.rsp_last;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tmo(input bit stuck);
    if (stuck) begin
      failures++;
      $display("[ERR] %0t wait %h %h", $time, 1'b1, 1'b0);
      wrap_up();
    end
  endtask

  task automatic step();
    @(posedge clk_in);
    #1;
  endtask

  task automatic run(input logic [10:0] op, input logic [3:0] cl, input logic [14:0] f,
                     input logic [10:0] len, input logic [9:0] exp);
    int unsigned h0, r0, c0, k, j;
    logic [31:0] hw;
    logic [10:0] n;
    id = id + 4'h1;
    hw = {2'b00, cl, id, len, op};
    n = (exp == MBR_ST_OK) ? len : 11'h000;
    h0 = hdr_n;
    r0 = retry_n;
    c0 = cmd_n;
    dq.delete();
    ucv = 1'b1;
    ucd = hw;
    ucl = 1'b1;
    for (k = 0; k < 20 && ucr !== 1'b1; k++) step();
    tmo(ucr !== 1'b1);
    step();
    ucv = 1'b0;
    for (k = 0; k < 20 && cmd_n == c0; k++) step();
    tmo(cmd_n == c0);
    chk(got_cmd, hw);
    chk(got_last, 1'b1);
    done = 1'b1;
    flt = f;
    slen = len;
    step();
    done = 1'b0;
    for (k = 0; k < n; k++) begin
      sdv = 1'b1;
      sdd = 32'hda7a_0000 + k;
      for (j = 0; j < 20 && sdr !== 1'b1; j++) step();
      tmo(sdr !== 1'b1);
      step();
    end
    sdv = 1'b0;
    for (k = 0; k < 40 && hdr_n == h0; k++) step();
    tmo(hdr_n == h0);
    // host may trail the header by a few cycles with data; retry pulses with the header
    repeat (4) step();
    chk(ust, exp);
    chk(ulen, n);
    chk(link_hdr[MBR_HDR_ID_LSB +: 4], id);
    chk(link_hdr[MBR_HDR_CL_LSB +: 4], cl);
    chk(dq.size(), n);
    for (k = 0; k < dq.size(); k++) chk(dq[k], 32'hda7a_0000 + k);
    chk(retry_n - r0, exp == MBR_ST_MALFORMED || exp == MBR_ST_OWNER_MISMATCH || exp == MBR_ST_TIMEOUT);
  endtask

  task automatic s_codes();
    logic [9:0] tbl [15] = '{MBR_ST_BOOT_UNDECODABLE, MBR_ST_FIRMWARE_UNDECODABLE, MBR_ST_SOURCE_DISABLED,
      MBR_ST_MALFORMED, MBR_ST_MANAGER_OCCUPIED, MBR_ST_UNPROGRAMMED_DEVICE, MBR_ST_HARDWARE_UNPREPARED,
      MBR_ST_BAD_ADDRESS, MBR_ST_AUTH_FAIL, MBR_ST_TIMEOUT, MBR_ST_HARDWARE_FAULT, MBR_ST_FLASH_PORT_FAULT,
      MBR_ST_GENERIC_FAILURE, MBR_ST_REPLY_ABSENT, MBR_ST_GENERIC_FAILURE};
    run(11'h040, 4'h3, 15'h0000, 11'h003, MBR_ST_OK);
    for (int i = 0; i < MBR_FAULT_W; i++) run(11'h040, 4'h2, 15'h0001 << i, 11'h002, tbl[i]);
    run(11'h040, 4'h2, 15'h0009, 11'h002, MBR_ST_BOOT_UNDECODABLE);
    run(11'h040, 4'h2, 15'h4040, 11'h000, MBR_ST_HARDWARE_UNPREPARED);
    run(MBR_OP_READ_DIE_ID, 4'h3, 15'h1000, 11'h002, MBR_ST_FUSE_CACHE_FAULT);
  endtask

  task automatic s_owner();
    run(MBR_OP_FLASH_LOCK, 4'h1, 15'h0000, 11'h000, MBR_ST_OK);
    chk(own, 1'b0);
    run(MBR_OP_FLASH_LOCK, 4'h1, 15'h0000, 11'h000, MBR_ST_FLASH_ALREADY_OWNED);
    chk(own, 1'b1);
    run(MBR_OP_FLASH_UNLOCK, 4'h2, 15'h0000, 11'h000, MBR_ST_OWNER_MISMATCH);
    run(MBR_OP_FLASH_UNLOCK, 4'h1, 15'h0000, 11'h000, MBR_ST_OK);
  endtask

  task automatic s_crypto();
    int unsigned k;
    creq = 1'b1;
    caddr = 32'h0000_1230;
    cdat = 64'h0123_4567_89ab_cdef;
    step();
    creq = 1'b0;
    for (k = 0; k < 20 && awv !== 1'b1; k++) step();
    tmo(awv !== 1'b1);
    chk(wv, 1'b1);
    chk(awa, caddr);
    chk(wd[63:32], cdat[63:32]);
    chk(wd[31:0], cdat[31:0]);
    chk({wl, ws}, 9'h1ff);
    chk(busy, 1'b1);
    awr = 1'b1;
    wr = 1'b1;
    step();
    awr = 1'b0;
    wr = 1'b0;
    for (k = 0; k < 20 && br !== 1'b1; k++) step();
    tmo(br !== 1'b1);
    bv = 1'b1;
    step();
    bv = 1'b0;
    repeat (2) step();
    chk({busy, awv, wv}, 3'h0);
  endtask

  initial begin
    repeat (8) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    s_codes();
    s_owner();
    s_crypto();
    wrap_up();
  end
endmodule
`default_nettype wire
